// ### hw/blit_pkg.sv
// Purpose: Shared constants, types and fixed bitmaps of the pattern fill blit
// Assumes: 32-bit command dwords pushed through one register
// Notes:   Pattern bytes are rows; bit 7 of a byte is the leftmost pixel
// Notes on behaviour
// - loaded command: client 2, opcode 52h, length 07h
// - fixed command: opcode 59h, length 05h, no pattern
// - write only pixels inside clip and destination
// - pattern column is (X plus horizontal seed) mod 8
// - pattern row is (Y plus vertical seed) mod 8
// - header seeds: horizontal 14:12, vertical 10:8
// - one uses foreground, zero background or nothing
// - setup bit 28 set suppresses zero-bit writes
// - dword 7 low pattern half, dword 8 high
// - pattern byte n is scan line n
// - pixel 0 is bit 7, pixel 7 bit 0
// - codes 0 to 5 select the six hatches
// - codes 8 to 11 checker, wide, walking; others reserved
// - seeds shift fixed patterns like loaded ones
// - setup bits 25:24 choose 8, 565, 1555, 32
// - colours use low 8, 16 or 32 bits
// - at 32 bit, bits 21/20 gate alpha/colour
// - pitch signed dwords; tiled pitch has granularity limits
// - corner dwords hold signed Y high, X low
// - setup bit 30 enables clipping
// - fixed command bit 27 applies the bit mask
package blit_pkg;
  // Header fields
  localparam logic [2:0] CLIENT_2D  = 3'h2;
  localparam logic [6:0] OPC_LOADED = 7'h52;
  localparam logic [6:0] OPC_FIXED  = 7'h59;
  localparam logic [7:0] LEN_LOADED = 8'h07;
  localparam logic [7:0] LEN_FIXED  = 8'h05;
  localparam int H_CLI_HI = 31, H_CLI_LO = 29, H_OPC_HI = 28, H_OPC_LO = 22;
  localparam int H_ALPHA = 21, H_RGB = 20, H_FIX_HI = 18, H_FIX_LO = 15;
  localparam int H_HS_HI = 14, H_HS_LO = 12, H_TILE = 11;
  localparam int H_VS_HI = 10, H_VS_LO = 8, H_LEN_HI = 7;
  // Setup dword fields
  localparam int S_CLIP = 30, S_TRANSP = 28, S_BMASK = 27;
  localparam int S_DEP_HI = 25, S_DEP_LO = 24, S_ROP_HI = 23, S_ROP_LO = 16;
  localparam int S_PITCH_HI = 15;
  localparam logic [1:0] DEP_8 = 2'h0, DEP_565 = 2'h1, DEP_1555 = 2'h2;
  localparam logic [1:0] DEP_32 = 2'h3;
  // Packet dword positions
  localparam logic [3:0] DW_SETUP = 4'h1, DW_TL = 4'h2, DW_BR = 4'h3;
  localparam logic [3:0] DW_BASE = 4'h4, DW_BG = 4'h5, DW_FG = 4'h6;
  localparam logic [3:0] DW_PLO = 4'h7, DW_PHI = 4'h8;
  // Tiled pitch granules, in dwords: 512 bytes for X, 128 bytes for Y
  localparam logic [15:0] TILE_X_PITCH_MASK = 16'h007F;
  localparam logic [15:0] TILE_Y_PITCH_MASK = 16'h001F;
  // Register byte offsets
  localparam logic [7:0] REG_CMD = 8'h00, REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CLIP_TL = 8'h08, REG_CLIP_BR = 8'h0C;
  localparam logic [7:0] REG_BITMASK = 8'h10, REG_CTRL = 8'h14;
  localparam int CTRL_TILE_Y = 0, CTRL_CLR_ERR = 1;
  localparam int STAT_BUSY = 0, STAT_ERR = 1, STAT_FSM_LO = 8;
  localparam logic [31:0] RST_BITMASK = 32'hFFFFFFFF;
  localparam logic [2:0]  PIX_MSB = 3'h7;
  // Built-in bitmaps, byte n is row n
  localparam logic [63:0] PAT_FDIAG  = 64'h0102040810204080;
  localparam logic [63:0] PAT_BDIAG  = 64'h8040201008040201;
  localparam logic [63:0] PAT_CROSS  = 64'h08080808FF080808;
  localparam logic [63:0] PAT_DCROSS = 64'h8142241818244281;
  localparam logic [63:0] PAT_CHECK  = 64'hAA55AA55AA55AA55;
  localparam logic [63:0] PAT_WIDE   = 64'h33CC33CC33CC33CC;
  localparam logic [63:0] PAT_WALK1  = 64'h1122448811224488;
  localparam logic [63:0] PAT_WALK0  = 64'hEEDDBB77EEDDBB77;

  typedef enum logic [4:0] {
    S_IDLE = 5'h01, S_COLLECT = 5'h02, S_SETUP = 5'h04,
    S_DRAW = 5'h08, S_WAIT = 5'h10
  } fsm_t;

  // One pixel write toward graphics memory
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0]  be;
    logic [31:0] bitmask;
    logic [7:0]  rop;
  } mem_cmd_t;

  typedef struct packed {
    fsm_t              st;
    logic [31:0]       hdr, setup, tl, br, base, bg, fg;
    logic [63:0]       pat;
    logic [3:0]        idx, last_idx;
    logic signed [15:0] x, y, xs, xe, ye;
    logic [31:0]       clip_tl, clip_br, bitmask;
    logic              tile_y, err, av_wait, req, pix_bit;
    logic [31:0]       rdata;
    mem_cmd_t          cmd;
  } blit_state_t;

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge_be(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction
endpackage

// ### hw/mono_pattern_fill_blit.sv
// Purpose: Executes loaded and fixed monochrome 8x8 pattern fill commands
// Assumes: Avalon-MM slave, byte addresses, one word per register
// Notes:   Pixels leave as single word writes with lane enables and ROP code
//
// Implementation choices: the Avalon-MM interface to the registers and the address map.
module mono_pattern_fill_blit #(
  parameter logic [63:0] HATCH_H_BITS = 64'h00000000FF000000,
  parameter logic [63:0] HATCH_V_BITS = 64'h0808080808080808
) (
  input  wire logic               core_clk_i,
  input  wire logic               rst_i,
  input  wire logic [7:0]         avs_address_i,
  input  wire logic               avs_read_i,
  input  wire logic               avs_write_i,
  input  wire logic [31:0]        avs_writedata_i,
  input  wire logic [3:0]         avs_byteenable_i,
  output logic                    avs_waitrequest_o,
  output logic [31:0]             avs_readdata_o,
  input  wire logic               mem_ack_i,
  output logic                    mem_req_o,
  output blit_pkg::mem_cmd_t      mem_cmd_o
);
  import blit_pkg::*;

  blit_state_t q;                 // All registered state
  blit_state_t n;                 // Next value of q
  logic        acc_wr;            // Write takes effect this edge
  logic        cmd_stall;         // Command push while drawing
  logic        err_set;           // Malformed packet seen
  logic        err_clr;           // Software clear request
  logic        hdr_ok;            // Header decodes to a known command
  logic        is_fixed;          // Current packet is the fixed variant
  logic        step;              // Advance to next pixel
  logic [64:0] fixed_sel;         // {valid, bitmap} for fixed code
  logic [31:0] merged;            // Write data merged by byte enables
  logic [15:0] pitch;             // Destination pitch field
  logic signed [15:0] lo_x, lo_y, hi_x, hi_y;  // Effective draw bounds
  logic [2:0]  prow, pcol;        // Pattern row and column
  logic [7:0]  pbyte;             // Selected pattern scan line
  logic        pbit;              // Pattern bit for this pixel
  logic [31:0] color;             // Colour fed to the raster op
  logic [31:0] yoff, addr;        // Byte offset of row, pixel address
  logic [1:0]  depth;             // Pixel depth code

  // Built-in bitmap table; horizontal and vertical hatch grids come from parameters
  always_comb begin
    unique case (q.hdr[H_FIX_HI:H_FIX_LO])
      4'h0: fixed_sel = {1'b1, HATCH_H_BITS};
      4'h1: fixed_sel = {1'b1, HATCH_V_BITS};
      4'h2: fixed_sel = {1'b1, PAT_FDIAG};
      4'h3: fixed_sel = {1'b1, PAT_BDIAG};
      4'h4: fixed_sel = {1'b1, PAT_CROSS};
      4'h5: fixed_sel = {1'b1, PAT_DCROSS};
      4'h8: fixed_sel = {1'b1, PAT_CHECK};
      4'h9: fixed_sel = {1'b1, PAT_WIDE};
      4'hA: fixed_sel = {1'b1, PAT_WALK1};
      4'hB: fixed_sel = {1'b1, PAT_WALK0};
      // Reserved codes are refused, never drawn
      default: fixed_sel = {1'b0, 64'h0};
    endcase
  end

  // Pixel datapath: pattern lookup, colour and address
  always_comb begin
    depth = q.setup[S_DEP_HI:S_DEP_LO];
    pitch = q.setup[S_PITCH_HI:0];
    // Three-bit sums wrap, giving modulo 8 even for negative coordinates
    prow  = q.y[2:0] + q.hdr[H_VS_HI:H_VS_LO];
    pcol  = q.x[2:0] + q.hdr[H_HS_HI:H_HS_LO];
    pbyte = q.pat[{prow, 3'h0} +: 8];
    pbit  = pbyte[PIX_MSB - pcol];
    color = pbit ? q.fg : q.bg;
    // Signed pitch in dwords; tiled surfaces use the same row stride
    yoff  = 32'($signed(q.y) * $signed(pitch)) << 2;
    addr  = q.base + yoff;
    unique case (depth)
      DEP_8:   addr = addr + 32'($signed(q.x));
      DEP_565,
      DEP_1555: addr = addr + (32'($signed(q.x)) << 1);
      DEP_32:  addr = addr + (32'($signed(q.x)) << 2);
    endcase
  end

  // Command decode, register file, fill walk
  always_comb begin
    n         = q;
    err_set   = 1'b0;
    step      = 1'b0;
    lo_x      = '0;
    lo_y      = '0;
    hi_x      = '0;
    hi_y      = '0;
    is_fixed  = (q.hdr[H_OPC_HI:H_OPC_LO] == OPC_FIXED);
    merged    = '0;
    // Commands are held off with waitrequest while a fill is running
    cmd_stall = avs_write_i && (avs_address_i == REG_CMD) &&
                !(q.st inside {S_IDLE, S_COLLECT});
    acc_wr    = avs_write_i && !q.av_wait;
    err_clr   = 1'b0;
    hdr_ok    = (avs_writedata_i[H_CLI_HI:H_CLI_LO] == CLIENT_2D) && (
      ((avs_writedata_i[H_OPC_HI:H_OPC_LO] == OPC_LOADED) &&
       (avs_writedata_i[H_LEN_HI:0] == LEN_LOADED)) ||
      ((avs_writedata_i[H_OPC_HI:H_OPC_LO] == OPC_FIXED) &&
       (avs_writedata_i[H_LEN_HI:0] == LEN_FIXED)));

    // Answer one cycle after the request is seen, for a single cycle
    n.av_wait = 1'b1;
    if (q.av_wait && (avs_read_i || avs_write_i) && !cmd_stall) begin
      n.av_wait = 1'b0;
      unique case (avs_address_i)
        REG_STATUS:  n.rdata = 32'({q.st, 6'h0, q.err,
                                    !(q.st inside {S_IDLE, S_COLLECT})});
        REG_CLIP_TL: n.rdata = q.clip_tl;
        REG_CLIP_BR: n.rdata = q.clip_br;
        REG_BITMASK: n.rdata = q.bitmask;
        REG_CTRL:    n.rdata = 32'(q.tile_y);
        // Command port and unmapped offsets read as zero
        default:     n.rdata = '0;
      endcase
    end

    // Register writes other than command pushes honour byte enables
    if (acc_wr) begin
      unique case (avs_address_i)
        REG_CLIP_TL: n.clip_tl = merge_be(q.clip_tl, avs_writedata_i,
                                          avs_byteenable_i);
        REG_CLIP_BR: n.clip_br = merge_be(q.clip_br, avs_writedata_i,
                                          avs_byteenable_i);
        REG_BITMASK: n.bitmask = merge_be(q.bitmask, avs_writedata_i,
                                          avs_byteenable_i);
        REG_CTRL: begin
          merged   = merge_be(32'(q.tile_y), avs_writedata_i,
                              avs_byteenable_i);
          n.tile_y = merged[CTRL_TILE_Y];
          err_clr  = merged[CTRL_CLR_ERR];
        end
        default: ;
      endcase
    end

    unique case (q.st)
      // Expect a header dword
      S_IDLE: begin
        if (acc_wr && avs_address_i == REG_CMD) begin
          if (hdr_ok) begin
            n.hdr      = avs_writedata_i;
            n.idx      = DW_SETUP;
            // Total dwords is length plus two; last index is length plus one
            n.last_idx = 4'(avs_writedata_i[H_LEN_HI:0]) + 4'h1;
            n.st       = S_COLLECT;
          end else begin
            err_set = 1'b1;  // Unknown header is dropped
          end
        end
      end
      // Gather the body dwords in packet order
      S_COLLECT: begin
        if (acc_wr && avs_address_i == REG_CMD) begin
          unique case (q.idx)
            DW_SETUP: n.setup = avs_writedata_i;
            DW_TL:    n.tl    = avs_writedata_i;
            DW_BR:    n.br    = avs_writedata_i;
            DW_BASE:  n.base  = avs_writedata_i;
            DW_BG:    n.bg    = avs_writedata_i;
            DW_FG:    n.fg    = avs_writedata_i;
            DW_PLO:   n.pat[31:0]  = avs_writedata_i;
            DW_PHI:   n.pat[63:32] = avs_writedata_i;
            default: ;
          endcase
          n.idx = q.idx + 4'h1;
          if (q.idx == q.last_idx) begin
            n.st = S_SETUP;
          end
        end
      end
      // Bounds, clipping, pattern source and legality
      S_SETUP: begin
        lo_x = $signed(q.tl[15:0]);
        lo_y = $signed(q.tl[31:16]);
        hi_x = $signed(q.br[15:0]);
        hi_y = $signed(q.br[31:16]);
        // Negative starts clip to zero even without a clip rectangle
        if (lo_x < 0) lo_x = '0;
        if (lo_y < 0) lo_y = '0;
        if (q.setup[S_CLIP]) begin
          if (lo_x < $signed(q.clip_tl[15:0])) lo_x = $signed(q.clip_tl[15:0]);
          if (lo_y < $signed(q.clip_tl[31:16]))
            lo_y = $signed(q.clip_tl[31:16]);
          if (hi_x > $signed(q.clip_br[15:0])) hi_x = $signed(q.clip_br[15:0]);
          if (hi_y > $signed(q.clip_br[31:16]))
            hi_y = $signed(q.clip_br[31:16]);
        end
        n.xs = lo_x;
        n.xe = hi_x;
        n.ye = hi_y;
        n.x  = lo_x;
        n.y  = lo_y;
        if (is_fixed) begin
          n.pat = fixed_sel[63:0];
        end
        if (is_fixed && !fixed_sel[64]) begin
          err_set = 1'b1;
          n.st    = S_IDLE;
        end else if (q.hdr[H_TILE] && (pitch[S_PITCH_HI] ||
                     ((pitch & (q.tile_y ? TILE_Y_PITCH_MASK
                                         : TILE_X_PITCH_MASK)) != '0))) begin
          err_set = 1'b1;
          n.st    = S_IDLE;
        end else if (lo_x >= hi_x || lo_y >= hi_y) begin
          n.st = S_IDLE;
        end else begin
          n.st = S_DRAW;
        end
      end
      // One pixel per visit; transparent zeros are skipped
      S_DRAW: begin
        if (!pbit && q.setup[S_TRANSP]) begin
          step = 1'b1;
        end else begin
          n.req         = 1'b1;
          n.pix_bit     = pbit;
          n.st          = S_WAIT;
          n.cmd.addr    = addr;
          n.cmd.rop     = q.setup[S_ROP_HI:S_ROP_LO];
          n.cmd.bitmask = (is_fixed && q.setup[S_BMASK]) ? q.bitmask
                                                         : RST_BITMASK;
          unique case (depth)
            DEP_8: begin
              n.cmd.data = {4{color[7:0]}};
              n.cmd.be   = 4'h1 << addr[1:0];
            end
            DEP_565, DEP_1555: begin
              n.cmd.data = {2{color[15:0]}};
              n.cmd.be   = addr[1] ? 4'hC : 4'h3;
            end
            DEP_32: begin
              n.cmd.data = color;
              n.cmd.be   = {q.hdr[H_ALPHA], {3{q.hdr[H_RGB]}}};
            end
          endcase
        end
      end
      // Hold the write until memory takes it
      S_WAIT: begin
        if (mem_ack_i) begin
          n.req = 1'b0;
          step  = 1'b1;
        end
      end
    endcase

    // Raster walk, left to right then top to bottom, ends exclusive
    if (step) begin
      n.st = S_DRAW;
      if (q.x + 16'sh1 >= q.xe) begin
        n.x = q.xs;
        n.y = q.y + 16'sh1;
        if (q.y + 16'sh1 >= q.ye) begin
          n.st = S_IDLE;
        end
      end else begin
        n.x = q.x + 16'sh1;
      end
    end

    // A fresh error wins over a clear in the same cycle
    n.err = (q.err && !err_clr) || err_set;
  end

  // State register
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      q         <= '0;
      q.st      <= S_IDLE;
      q.av_wait <= 1'b1;
      q.bitmask <= RST_BITMASK;
    end else begin
      q <= n;
    end
  end

  assign avs_waitrequest_o = q.av_wait;
  assign avs_readdata_o    = q.rdata;
  assign mem_req_o         = q.req;
  assign mem_cmd_o         = q.cmd;

  default clocking dc @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  property p_inside;
    mem_req_o |-> (q.x >= q.xs && q.x < q.xe && q.y < q.ye && q.x >= 0);
  endproperty
  a_inside: assert property (p_inside)
    else $error("pixel write outside fill area");

  property p_transp;
    $rose(mem_req_o) && q.setup[S_TRANSP] |-> q.pix_bit;
  endproperty
  a_transp: assert property (p_transp)
    else $error("zero pattern bit written in transparent mode");

  property p_fg_color;
    $rose(mem_req_o) && depth == DEP_32 |->
      mem_cmd_o.data == (q.pix_bit ? q.fg : q.bg);
  endproperty
  a_fg_color: assert property (p_fg_color)
    else $error("wrong colour for pattern bit");

  property p_lanes32;
    mem_req_o && depth == DEP_32 |->
      mem_cmd_o.be == {q.hdr[H_ALPHA], {3{q.hdr[H_RGB]}}};
  endproperty
  a_lanes32: assert property (p_lanes32)
    else $error("32 bit byte mask not applied");

  property p_depth8;
    mem_req_o && depth == DEP_8 |->
      mem_cmd_o.data[31:8] == {3{mem_cmd_o.data[7:0]}} &&
      $countones(mem_cmd_o.be) == 1;
  endproperty
  a_depth8: assert property (p_depth8)
    else $error("8 bit pixel not replicated to one lane");

  property p_bitmask;
    mem_req_o && !(is_fixed && q.setup[S_BMASK]) |->
      mem_cmd_o.bitmask == RST_BITMASK;
  endproperty
  a_bitmask: assert property (p_bitmask)
    else $error("bit mask applied while disabled");

  property p_bad_len;
    q.st == S_IDLE && acc_wr && avs_address_i == REG_CMD &&
      avs_writedata_i[H_OPC_HI:H_OPC_LO] == OPC_LOADED &&
      avs_writedata_i[H_LEN_HI:0] != LEN_LOADED |=> q.err && q.st == S_IDLE;
  endproperty
  a_bad_len: assert property (p_bad_len)
    else $error("malformed loaded header accepted");

  property p_empty;
    q.st == S_SETUP && (n.xs >= n.xe) |=> q.st == S_IDLE && !mem_req_o;
  endproperty
  a_empty: assert property (p_empty)
    else $error("empty rectangle started a fill");

  property p_wait_pulse;
    !avs_waitrequest_o |=> avs_waitrequest_o;
  endproperty
  a_wait_pulse: assert property (p_wait_pulse)
    else $error("waitrequest low for more than one cycle");
endmodule

// ### tb/mem_responder.sv
// Purpose: Graphics memory stand-in that accepts single pixel writes
// Assumes: One request at a time; ack is a one-cycle pulse
// Notes:   Slow mode stalls each request for three extra cycles
module mem_responder (
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  input  wire logic slow_i,
  input  wire logic mem_req_i,
  output logic      mem_ack_o
);
  logic [1:0] wait_q;  // Cycles already spent on this request

  // Answer promptly or after a stall, never twice for one request
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wait_q    <= 2'h0;
      mem_ack_o <= 1'b0;
    end else begin
      mem_ack_o <= 1'b0;
      // Skip the cycle of our own ack, the request is still seen then
      if (mem_req_i && !mem_ack_o) begin
        if (wait_q == (slow_i ? 2'h3 : 2'h0)) begin
          mem_ack_o <= 1'b1;
          wait_q    <= 2'h0;
        end else begin
          wait_q <= wait_q + 2'h1;
        end
      end
    end
  end
endmodule

// ### tb/mono_pattern_fill_blit_test.sv
// Purpose: Self-checking bench of the mono pattern fill engine
// Assumes: Avalon-MM master tasks; memory side is mem_responder
// Notes:   Expected pixel streams are rebuilt here from packet fields
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin \
  errors++; $display("BAD %s exp %h got %h", nm, ex, gt); end end
module mono_pattern_fill_blit_test import blit_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  // Hatch bitmaps handed to the design, so the table below agrees
  localparam logic [63:0] HH = 64'h00000000FF000000;
  localparam logic [63:0] HV = 64'h0808080808080808;
  // Built-in bitmaps by code: byte n is row n, bit 7 is pixel 0
  localparam logic [63:0] FIX [12] = '{HH, HV, 64'h0102040810204080,
    64'h8040201008040201, 64'h08080808FF080808, 64'h8142241818244281,
    64'h0, 64'h0, 64'hAA55AA55AA55AA55, 64'h33CC33CC33CC33CC,
    64'h1122448811224488, 64'hEEDDBB77EEDDBB77};
  logic        clk, rst, rd, wr, wq, ack, req, slow;  // Control lines
  logic [7:0]  adr;                                  // Register offset
  logic [3:0]  ben;                                  // Byte lanes
  logic [31:0] wd, rdata, q, clip_tl, clip_br;       // Bus data, clip
  logic [31:0] bmask, base, bg, fg;                  // Packet constants
  mem_cmd_t    cmd;                                  // Pixel write
  mem_cmd_t    got[$], exp_q[$];                     // Seen, expected
  int          errors, n_checks;                     // Verdict counts

  mono_pattern_fill_blit #(.HATCH_H_BITS(HH), .HATCH_V_BITS(HV))
    i_mono_pattern_fill_blit (.core_clk_i(clk), .rst_i(rst),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wd), .avs_byteenable_i(ben),
    .avs_waitrequest_o(wq), .avs_readdata_o(rdata), .mem_ack_i(ack),
    .mem_req_o(req), .mem_cmd_o(cmd));
  mem_responder i_mem_responder (.core_clk_i(clk), .rst_i(rst),
    .slow_i(slow), .mem_req_i(req), .mem_ack_o(ack));

  // Free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Record each pixel at the edge where memory takes it
  always @(posedge clk) begin
    if (req === 1'b1 && ack === 1'b1) got.push_back(cmd);
  end

  // Verdict and end of run, shared with the watchdog
  task automatic report_and_stop;
    if (errors == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // One Avalon transfer; held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    adr <= a;
    wd  <= d;
    wr  <= w;
    rd  <= !w;
    // No cap here: a slave that never answers is caught by the watchdog
    do begin
      @(posedge clk);
    end while (wq !== 1'b0);
    r = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, q);
  endtask

  function automatic logic [31:0] hdr(logic [6:0] op, logic [1:0] am,
      logic [3:0] c, logic [2:0] hs, logic [2:0] vs, logic [7:0] len);
    return {3'h2, op, am, 1'b0, c, hs, 1'b0, vs, len};
  endfunction
  function automatic logic [31:0] stp(logic ce, logic tr, logic bm,
      logic [1:0] dp, logic [7:0] rop, logic [15:0] pitch);
    return {1'b0, ce, 1'b0, tr, bm, 1'b0, dp, rop, pitch};
  endfunction

  // Send a packet (header alone when it cannot decode), wait for idle,
  // then compare the pixel stream with one rebuilt from the fields.
  // Reserved codes and bad pitches only show after the body arrives.
  task automatic fill(input logic [31:0] h, s, tl, br,
      input logic [63:0] p, input logic e);
    logic signed [15:0] x1, y1, x2, y2;
    logic [63:0] pt;
    logic        b;
    logic        hok;
    logic [31:0] col;
    logic [31:0] body [6];
    int          bpp;
    mem_cmd_t    m;
    got.delete();
    exp_q.delete();
    hok = h[31:29] == CLIENT_2D &&
          ((h[28:22] == OPC_LOADED && h[7:0] == LEN_LOADED) ||
           (h[28:22] == OPC_FIXED && h[7:0] == LEN_FIXED));
    wreg(REG_CMD, h);
    if (hok) begin
      body = '{s, tl, br, base, bg, fg};
      foreach (body[i]) wreg(REG_CMD, body[i]);
      if (h[28:22] == OPC_LOADED) begin
        wreg(REG_CMD, p[31:0]);
        wreg(REG_CMD, p[63:32]);
      end
    end
    do begin
      bus(1'b0, REG_STATUS, 32'h0, q);
    end while (q[0] !== 1'b0);
    `CHK("err", e, q[1])
    if (e) begin
      wreg(REG_CTRL, 32'h2);
      bus(1'b0, REG_STATUS, 32'h0, q);
      `CHK("err clear", 1'b0, q[1])
    end
    pt = (h[28:22] == OPC_LOADED) ? p : FIX[h[18:15]];
    x1 = tl[15:0];
    y1 = tl[31:16];
    x2 = br[15:0];
    y2 = br[31:16];
    if (x1 < 0) x1 = 0;
    if (y1 < 0) y1 = 0;
    if (s[30]) begin
      if ($signed(clip_tl[15:0]) > x1) x1 = clip_tl[15:0];
      if ($signed(clip_tl[31:16]) > y1) y1 = clip_tl[31:16];
      if ($signed(clip_br[15:0]) < x2) x2 = clip_br[15:0];
      if ($signed(clip_br[31:16]) < y2) y2 = clip_br[31:16];
    end
    bpp = (s[25:24] == 2'h0) ? 1 : (s[25:24] == 2'h3) ? 4 : 2;
    for (int y = y1; y < y2 && !e; y++) begin
      for (int x = x1; x < x2; x++) begin
        b = pt[((y + h[10:8]) & 7) * 8 + 7 - ((x + h[14:12]) & 7)];
        if (b || !s[28]) begin
          col = b ? fg : bg;
          m.addr = base + 32'(y * $signed(s[15:0]) * 4 + x * bpp);
          m.data = bpp == 1 ? {4{col[7:0]}} :
                   bpp == 2 ? {2{col[15:0]}} : col;
          m.be = bpp == 1 ? 4'h1 << m.addr[1:0] :
                 bpp == 2 ? 4'h3 << m.addr[1:0] : {h[21], {3{h[20]}}};
          m.bitmask = (h[28:22] == OPC_FIXED && s[27]) ? bmask : '1;
          m.rop = s[23:16];
          exp_q.push_back(m);
        end
      end
    end
    `CHK("pixel count", exp_q.size(), got.size())
    foreach (exp_q[i]) begin
      if (i < got.size()) begin
        m = got[i];
        `CHK("pixel", exp_q[i], m)
        `CHK("addr", exp_q[i].addr, m.addr)
        `CHK("data", exp_q[i].data, m.data)
        `CHK("lanes", exp_q[i].be, m.be)
        `CHK("mask", exp_q[i].bitmask, m.bitmask)
        `CHK("rop", exp_q[i].rop, m.rop)
      end
    end
  endtask

  // Bit mask reset value, read-back and an unmapped offset
  task automatic s_regs;
    bus(1'b0, REG_BITMASK, 32'h0, q);
    `CHK("bitmask reset", 32'hFFFFFFFF, q)
    clip_tl = 32'h00000003;
    clip_br = 32'h00020009;
    wreg(REG_CLIP_TL, clip_tl);
    wreg(REG_CLIP_BR, clip_br);
    bus(1'b0, REG_CLIP_BR, 32'h0, q);
    `CHK("clip br", clip_br, q)
    bus(1'b0, 8'h3C, 32'h0, q);
    `CHK("unmapped", 32'h0, q)
    bmask = 32'h00FF00FF;
    wreg(REG_BITMASK, bmask);
  endtask
  // Loaded pattern, opaque, 8 bit, seeds, stalled memory
  task automatic s_loaded;
    slow <= 1'b1;
    fill(hdr(OPC_LOADED, 2'h3, 4'h0, 3'h3, 3'h5, LEN_LOADED),
      stp(1'b0, 1'b0, 1'b0, DEP_8, 8'hF0, 16'h0010),
      32'h00010002, 32'h00040008, 64'h0123456789ABCDEF, 1'b0);
  endtask
  // Transparent, 32 bit with alpha held, negative X1 and pitch
  task automatic s_transp;
    slow <= 1'b0;
    fill(hdr(OPC_LOADED, 2'h1, 4'h0, 3'h7, 3'h2, LEN_LOADED),
      stp(1'b0, 1'b1, 1'b0, DEP_32, 8'hCC, 16'hFFF0),
      32'h0000FFFE, 32'h00030005, 64'hF00F8001A55A3CC3, 1'b0);
  endtask
  // Every built-in code, with clip, mask and seeds varied
  task automatic s_fixed;
    logic [3:0] codes [10] = '{0, 1, 2, 3, 4, 5, 8, 9, 10, 11};
    foreach (codes[i]) begin
      fill(hdr(OPC_FIXED, 2'h3, codes[i], 3'(i), 3'(~i), LEN_FIXED),
        stp(i != 0, i[1], i[2], i[0] ? DEP_565 : DEP_1555, 8'(i), 16'h8),
        32'h00000001, 32'h0002000B, 64'h0, 1'b0);
    end
  endtask
  // Refused headers, reserved codes and an empty rectangle
  task automatic s_errors;
    fill(hdr(OPC_FIXED, 2'h3, 4'h6, 3'h0, 3'h0, LEN_FIXED), 0, 0, 0, 0, 1'b1);
    fill(hdr(OPC_FIXED, 2'h3, 4'hC, 3'h0, 3'h0, LEN_FIXED), 0, 0, 0, 0, 1'b1);
    fill(hdr(OPC_LOADED, 2'h3, 4'h0, 3'h0, 3'h0, LEN_FIXED), 0, 0, 0, 0, 1'b1);
    fill(hdr(OPC_LOADED, 2'h3, 4'h0, 3'h0, 3'h0, LEN_LOADED) ^ 32'h20000000,
      0, 0, 0, 0, 1'b1);
    fill(hdr(OPC_FIXED, 2'h3, 4'h8, 3'h0, 3'h0, LEN_FIXED),
      stp(1'b0, 1'b0, 1'b0, DEP_8, 8'h0, 16'h8),
      32'h00020002, 32'h00050002, 64'h0, 1'b0);
  endtask
  // Tiled destination: 32-dword pitch breaks X granules, fits Y granules
  task automatic s_tiled;
    fill(hdr(OPC_FIXED, 2'h3, 4'h8, 3'h1, 3'h2, LEN_FIXED) | 32'h800,
      stp(1'b0, 1'b0, 1'b0, DEP_8, 8'h0, 16'h20), 32'h0, 32'h00020004,
      64'h0, 1'b1);
    wreg(REG_CTRL, 32'h1);
    bus(1'b0, REG_CTRL, 32'h0, q);
    `CHK("tile y", 32'h1, q)
    fill(hdr(OPC_FIXED, 2'h3, 4'h8, 3'h1, 3'h2, LEN_FIXED) | 32'h800,
      stp(1'b0, 1'b0, 1'b0, DEP_8, 8'h0, 16'h20), 32'h0, 32'h00020004,
      64'h0, 1'b0);
    wreg(REG_CTRL, 32'h0);
  endtask

  // Main sequence: reset for four cycles, then every scenario
  initial begin
    rst = 1'b1;
    {rd, wr, slow, adr, wd, errors, n_checks} = '0;
    ben = 4'hF;
    base = 32'h00010000;  // 4K aligned for tiled fills
    bg = 32'h11223344;
    fg = 32'h55667788;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    s_regs();
    s_loaded();
    s_transp();
    s_fixed();
    s_errors();
    s_tiled();
    report_and_stop();
  end
  // Watchdog: a clean run takes about a thousand cycles; give up at 30k
  initial begin
    #300000;
    errors++;
    report_and_stop();
  end
endmodule
